// ===== shared/dtc_pkg.sv
package dtc_pkg;

  // Device clock and burst timing
  localparam int unsigned CLK_HZ        = 25_000_000; // Device clock rate
  localparam int unsigned BURST_MS      = 50;         // Tone burst, also pause
  localparam int unsigned BURST_CYC     = CLK_HZ / 1000 * BURST_MS; // Cycles per burst
  localparam int unsigned CP_FACTOR     = 2;          // Stretch in call-progress mode

  // Access codes: {register_select_line, read}
  localparam logic [1:0]  ACC_TX_WR     = 2'h0;       // Transmit data write
  localparam logic [1:0]  ACC_RX_RD     = 2'h1;       // Receive data read
  localparam logic [1:0]  ACC_CTL_WR    = 2'h2;       // Control write
  localparam logic [1:0]  ACC_STAT_RD   = 2'h3;       // Status read

  // Values after reset
  localparam logic [3:0]  CTL_FIRST_RST  = 4'h0;
  localparam logic [3:0]  CTL_SECOND_RST = 4'h0;
  localparam logic [3:0]  STATUS_RST     = 4'h0;
  localparam logic [3:0]  RX_DATA_RST    = 4'h0;

  // control_first, b3..b0
  typedef struct packed {
    logic bank_redirect;    // Next control write goes to control_second
    logic irq_en;           // Interrupt mode
    logic tone_mode_select; // 1 call progress, 0 DTMF
    logic tone_output_enable;
  } dtc_ctl_first_t;

  // tx_mode_control (control_second), b3..b0
  typedef struct packed {
    logic column;           // Single tone: 1 column, 0 row
    logic single;           // 1 single tone, 0 dual
    logic test;             // Pin shows inverted delayed steering
    logic burst_off;        // 0 burst mode, 1 free-running tones
  } dtc_ctl_second_t;

  // transceiver_status, b3..b0
  typedef struct packed {
    logic steer;            // Absence of tone validly detected
    logic rx_full;          // Receive data register full
    logic tx_ready;         // Pause over, transmitter wants data
    logic irq;              // b1 or b2 has been set
  } dtc_status_t;

  // Bus pins as they arrive, unsynchronised
  typedef struct packed {
    logic       cs_b;       // Chip select, active low
    logic       sel;        // register_select_line
    logic       rd;         // 1 read, 0 write
    logic       en;         // Bus enable strobe, access ends on its fall
    logic [3:0] data;
  } dtc_bus_pins_t;

  // Controls toward the tone generator
  typedef struct packed {
    logic       tone_on;    // Tone output active now
    logic       single;
    logic       column;
    logic       cp_mode;
    logic [3:0] code;       // Tone code last written
  } dtc_tone_ctl_t;

endpackage : dtc_pkg

// ===== hw/dtc_sync.sv
`timescale 1ns/1ps
module dtc_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import dtc_pkg::*;

  // Two flops per bit; the first is read only by the second
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic meta_q; // First stage, may go metastable
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        meta_q      <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        meta_q      <= async_in[i];
        sync_out[i] <= meta_q;
      end
    end
  end

endmodule : dtc_sync

// ===== hw/dtc_ctrl_status.sv
`timescale 1ns/1ps
// How it works
// - Burst bit 0 timed bursts, 1 free tones
// - Transmit write starts burst, then equal pause
// - Pause end sets ready, raises interrupt
// - Call progress plus burst doubles both lengths
// - Ready flag 100 ms after write, 200 extended
// - Test bit routes inverted steering to pin
// - Single/dual bit chooses one or two tones
// - Column/row bit: 0 row, 1 column
// - Status b0 follows b1/b2, clears on read
// - Ready sets at pause end, clears read/non-burst
// - Receive full sets on new data, read clears
// - Steering flag set on absence, cleared on tone
// - Plain burst mode: 50 ms tone, 50 pause
// - Select and read lines pick the access
// - Redirect bit sends one write to second
// - Interrupt pin low on receive or ready
module dtc_ctrl_status #(
  parameter int unsigned BURST_CYCLES = dtc_pkg::BURST_CYC // Cycles per 50 ms burst
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Processor bus pins
  input  wire dtc_pkg::dtc_bus_pins_t bus_pins,
  output logic                  [3:0] data_out,
  output logic                        data_oe,
  // Tone receiver, same clock
  input  wire logic                   rx_valid,
  input  wire logic             [3:0] rx_code,
  input  wire logic                   steer_delayed,
  input  wire logic                   cp_tone,
  // Tone generator
  output dtc_pkg::dtc_tone_ctl_t      tone_ctl,
  output logic                        tx_load,
  // Open-drain interrupt_tone_pin
  output logic                        irq_out,
  output logic                        irq_oe
);
  import dtc_pkg::*;

  localparam int unsigned CW = $clog2(CP_FACTOR * BURST_CYCLES) + 1; // Timer width

  typedef enum logic [1:0] {PH_IDLE, PH_TONE, PH_PAUSE} dtc_phase_t;

  dtc_bus_pins_t   pins_s;        // Synchronised pins
  logic            en_prev_q;     // Strobe one cycle back
  logic      [3:0] wr_data_q;     // Data held while strobe high
  dtc_ctl_first_t  ctl1_q;        // control_first
  dtc_ctl_second_t ctl2_q;        // tx_mode_control
  logic            redirect_q;    // One-shot redirect armed
  dtc_status_t     status_q;      // transceiver_status
  logic      [3:0] rx_data_q;     // Receive data register
  dtc_phase_t      phase_q;       // Burst timer phase
  logic   [CW-1:0] cnt_q;         // Cycles into current phase
  logic   [CW-1:0] limit;         // Last count of a phase
  logic            access;        // Strobe fall with chip selected
  logic      [1:0] acc_code;      // {select, read}
  logic            tx_wr;
  logic            ctl_wr;
  logic            stat_rd;
  logic            rx_ok;         // Decoded tone accepted
  logic            pause_done;    // Last cycle of the pause

  // Pins cross into the device clock
  dtc_sync #(
    .WIDTH ($bits(dtc_bus_pins_t))
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in (bus_pins),
    .sync_out (pins_s)
  );

  // Access decode, taken on the strobe's falling edge
  assign access   = en_prev_q && !pins_s.en && !pins_s.cs_b;
  assign acc_code = {pins_s.sel, pins_s.rd};
  assign tx_wr    = access && (acc_code == ACC_TX_WR);
  assign ctl_wr   = access && (acc_code == ACC_CTL_WR);
  assign stat_rd  = access && (acc_code == ACC_STAT_RD);
  // No decoding while the call-progress filter is in
  assign rx_ok    = rx_valid && !ctl1_q.tone_mode_select;

  // Strobe history and write data capture
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_prev_q <= 1'b0;
      wr_data_q <= 4'h0;
    end
    else
    begin
      en_prev_q <= pins_s.en;
      // Held so the fall does not sample settling data
      if (pins_s.en)
        wr_data_q <= pins_s.data;
    end
  end

  // Control registers with one-shot redirect
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl1_q     <= CTL_FIRST_RST;
      ctl2_q     <= CTL_SECOND_RST;
      redirect_q <= 1'b0;
    end
    else if (ctl_wr)
    begin
      if (redirect_q)
      begin
        // Only this write lands in the second register
        ctl2_q     <= wr_data_q;
        redirect_q <= 1'b0;
      end
      else
      begin
        ctl1_q     <= wr_data_q;
        redirect_q <= wr_data_q[3];
      end
    end
  end

  // Receive data register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rx_data_q <= RX_DATA_RST;
    else if (rx_ok)
      rx_data_q <= rx_code;
  end

  // Phase length, doubled with call progress in burst mode
  assign limit = ctl1_q.tone_mode_select
               ? CW'(CP_FACTOR * BURST_CYCLES - 1)
               : CW'(BURST_CYCLES - 1);
  assign pause_done = (phase_q == PH_PAUSE) && (cnt_q == limit);

  // Burst and pause timer
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_q <= PH_IDLE;
      cnt_q   <= '0;
    end
    else if (ctl2_q.burst_off)
    begin
      // Free-running tones: the timer stays parked
      phase_q <= PH_IDLE;
      cnt_q   <= '0;
    end
    else if (tx_wr)
    begin
      // A new code restarts the burst even mid-pause
      phase_q <= PH_TONE;
      cnt_q   <= '0;
    end
    else if (phase_q != PH_IDLE)
    begin
      if (cnt_q == limit)
      begin
        cnt_q   <= '0;
        phase_q <= (phase_q == PH_TONE) ? PH_PAUSE : PH_IDLE;
      end
      else
        cnt_q <= cnt_q + CW'(1);
    end
  end

  // Status flags; a set in the read cycle wins over the clear
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      status_q <= STATUS_RST;
    else
    begin
      if (ctl2_q.burst_off)
        status_q.tx_ready <= 1'b0;
      else if (pause_done)
        status_q.tx_ready <= 1'b1;
      else if (stat_rd)
        status_q.tx_ready <= 1'b0;
      if (rx_ok)
        status_q.rx_full <= 1'b1;
      else if (stat_rd)
        status_q.rx_full <= 1'b0;
      if (rx_ok || (pause_done && !ctl2_q.burst_off))
        status_q.irq <= 1'b1;
      else if (stat_rd)
        status_q.irq <= 1'b0;
      // Delayed steering low means tone absent
      status_q.steer <= !steer_delayed;
    end
  end

  // Read data and bus drive, registered
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_out <= 4'h0;
      data_oe  <= 1'b0;
    end
    else
    begin
      data_oe  <= pins_s.en && !pins_s.cs_b && pins_s.rd;
      data_out <= pins_s.sel ? status_q : rx_data_q;
    end
  end

  // Tone generator controls
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tone_ctl <= '0;
      tx_load  <= 1'b0;
    end
    else
    begin
      tx_load          <= tx_wr;
      tone_ctl.single  <= ctl2_q.single;
      tone_ctl.column  <= ctl2_q.column;
      tone_ctl.cp_mode <= ctl1_q.tone_mode_select;
      if (tx_wr)
        tone_ctl.code <= wr_data_q;
      // Burst mode gates by timer, otherwise the host decides
      tone_ctl.tone_on <= ctl1_q.tone_output_enable
                          && (ctl2_q.burst_off || (phase_q == PH_TONE));
    end
  end

  // Interrupt/tone pin, open drain; low while enabled
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end
    else
    begin
      irq_out <= 1'b0;
      // Test mode assumes the host already chose DTMF mode
      if (ctl2_q.test)
        irq_oe <= steer_delayed;
      else if (ctl1_q.irq_en && ctl1_q.tone_mode_select)
        irq_oe <= !cp_tone;
      else
        irq_oe <= ctl1_q.irq_en && status_q.irq;
    end
  end

  // Checking helpers: cycles since the last transmit write
  logic [CW+1:0] since_wr_q;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      since_wr_q <= '0;
    else if (tx_wr)
      since_wr_q <= '0;
    else if (since_wr_q != '1)
      since_wr_q <= since_wr_q + (CW+2)'(1);
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_tx_start;
    tx_wr && !ctl2_q.burst_off && !ctl_wr;
  endsequence
  sequence s_tone_runs;
    (phase_q == PH_TONE)[*2];
  endsequence

  chk_burst_start: assert property (s_tx_start |=> s_tone_runs)
    else $error("burst did not start after transmit write");
  chk_ready_delay: assert property (pause_done && !ctl_wr |->
    since_wr_q == (CW+2)'(2 * (32'(limit) + 1) - 1))
    else $error("ready delay not two phase lengths");
  chk_cp_double: assert property (pause_done && ctl1_q.tone_mode_select |->
    32'(limit) == CP_FACTOR * BURST_CYCLES - 1)
    else $error("call progress burst not doubled");
  chk_ready_set: assert property (pause_done && !ctl2_q.burst_off
    |=> status_q.tx_ready && status_q.irq)
    else $error("ready or irq flag missed");
  chk_nonburst_clr: assert property (ctl2_q.burst_off |=> !status_q.tx_ready)
    else $error("ready set in non-burst mode");
  chk_rx_full_set: assert property (rx_ok |=> status_q.rx_full && status_q.irq)
    else $error("receive full flag missed");
  chk_read_clears: assert property (stat_rd && !rx_ok && !pause_done
    |=> !status_q.irq && !status_q.rx_full)
    else $error("status read did not clear");
  chk_test_pin: assert property (ctl2_q.test |=> irq_oe == $past(steer_delayed))
    else $error("test pin not following steering");
  chk_redirect_once: assert property (ctl_wr && redirect_q
    |=> !redirect_q ##0 ctl1_q == $past(ctl1_q))
    else $error("redirected write touched first register");
  chk_steer_flag: assert property (steer_delayed |=> !status_q.steer)
    else $error("steering flag not cleared by tone");

endmodule : dtc_ctrl_status

// ===== verif/dtc_host_model.sv
`timescale 1ns/1ps
module dtc_host_model (
  // Clock
  input  wire logic                   sys_clk,
  // Bus toward the device
  output dtc_pkg::dtc_bus_pins_t      pins,
  input  wire logic             [3:0] data_out,
  input  wire logic                   data_oe
);
  import dtc_pkg::*;

  // Idle bus, device not selected
  initial pins = '{1'b1, 1'b0, 1'b0, 1'b0, 4'ha};

  // One access; select, code and data outlast the strobe fall, since the
  // device only takes the access when it still sees chip select at the fall
  task automatic acc(input logic [1:0] code, input logic [3:0] wd,
                     output logic [3:0] rd_q, output logic oe);
    @(negedge sys_clk);
    pins = '{1'b0, code[1], code[0], 1'b1, code[0] ? ~pins.data : wd};
    repeat (4) @(negedge sys_clk);
    rd_q = data_out;
    oe   = data_oe;
    pins.en = 1'b0;
    repeat (3) @(negedge sys_clk);
    // Released data line shows the inverse of what it last carried
    pins = '{1'b1, code[1], code[0], 1'b0, ~pins.data};
    repeat (2) @(negedge sys_clk);
  endtask : acc

  // Redirect write, then second control register
  task automatic cfg(input logic [3:0] control_first, input logic [3:0] control_second);
    logic [3:0] d;
    logic       o;
    if (control_second[1])
      control_first[1] = 1'b0;
    acc(ACC_CTL_WR, control_first | 4'h8, d, o);
    acc(ACC_CTL_WR, control_second, d, o);
  endtask : cfg

  // Start-up initialisation
  task automatic sw_reset();
    logic [3:0] d;
    logic       o;
    acc(ACC_STAT_RD, 4'h0, d, o);
    acc(ACC_CTL_WR, 4'h0, d, o);
    acc(ACC_CTL_WR, 4'h0, d, o);
    acc(ACC_CTL_WR, 4'h8, d, o);
    acc(ACC_CTL_WR, 4'h0, d, o);
    acc(ACC_STAT_RD, 4'h0, d, o);
  endtask : sw_reset

  // Poll, then feed transmitter and drain receiver as flagged
  task automatic service(input logic [3:0] nxt, output logic [3:0] st,
                         output logic [3:0] rx);
    logic [3:0] d;
    logic       o;
    rx = 4'h0;
    acc(ACC_STAT_RD, 4'h0, st, o);
    if (st[1])
      acc(ACC_TX_WR, nxt, d, o);
    if (st[2])
      acc(ACC_RX_RD, 4'h0, rx, o);
  endtask : service
endmodule : dtc_host_model

// ===== verif/dtc_ctrl_status_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module dtc_ctrl_status_test;
  import dtc_pkg::*;
  localparam int B = 16; // Short burst, yet longer than one bus access
  logic             sys_clk       = 1'b0;
  logic             rst_b         = 1'b0;
  logic             rx_valid      = 1'b0;
  logic       [3:0] rx_code       = 4'h0;
  logic             steer_delayed = 1'b0;
  logic             cp_tone       = 1'b1;
  dtc_bus_pins_t    pins;
  dtc_tone_ctl_t    tone_ctl;
  logic       [3:0] data_out;
  logic             data_oe, tx_load, irq_out, irq_oe;
  int               err_count     = 0;
  int               compares      = 0;

  always #20 sys_clk = ~sys_clk;

  dtc_ctrl_status #(.BURST_CYCLES(B)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus_pins(pins), .data_out(data_out),
    .data_oe(data_oe), .rx_valid(rx_valid), .rx_code(rx_code),
    .steer_delayed(steer_delayed), .cp_tone(cp_tone), .tone_ctl(tone_ctl),
    .tx_load(tx_load), .irq_out(irq_out), .irq_oe(irq_oe));

  dtc_host_model host_u (.sys_clk(sys_clk), .pins(pins), .data_out(data_out),
    .data_oe(data_oe));

  task automatic end_of_test();
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // A used-up wait is a failure and ends the run
  task automatic guard(input int n);
    if (n >= 200)
    begin
      err_count++;
      end_of_test();
    end
  endtask : guard

  task automatic rd_stat(input logic [3:0] e);
    logic [3:0] d;
    logic       o;
    host_u.acc(ACC_STAT_RD, 4'h0, d, o);
    `CHK("status", e, d)
    `CHK("read_oe", 1'b1, o)
  endtask : rd_stat

  // Tone choice, and redirect lasting one write only
  task automatic t_sel();
    logic [3:0] d;
    logic       o;
    int         i;
    for (i = 0; i < 4; i++)
    begin
      host_u.cfg(4'h2, {i[1], i[0], 2'b00});
      `CHK("single", i[0], tone_ctl.single)
      `CHK("column", i[1], tone_ctl.column)
      `CHK("cp_on", 1'b1, tone_ctl.cp_mode)
      host_u.acc(ACC_CTL_WR, 4'h0, d, o);
      `CHK("cp_off", 1'b0, tone_ctl.cp_mode)
      `CHK("single_kept", i[0], tone_ctl.single)
    end
  endtask : t_sel

  // Burst, pause and ready; call progress doubles both
  task automatic t_burst(input logic cp);
    logic [3:0] d;
    logic       o;
    int         m, on, off, ld;
    m  = cp ? 2 : 1;
    ld = 0;
    host_u.cfg({2'b01, cp, 1'b1}, 4'h0);
    rd_stat(4'h8);
    fork
      host_u.acc(ACC_TX_WR, 4'h7, d, o);
      begin
        // Load pulse stands one cycle, so it is counted while waiting
        for (off = 0; off < 200 && tone_ctl.tone_on !== 1'b1; off++)
        begin
          ld += int'(tx_load);
          @(negedge sys_clk);
        end
        guard(off);
        for (on = 0; on < 200 && tone_ctl.tone_on === 1'b1; on++) @(negedge sys_clk);
        guard(on);
      end
    join
    `CHK("tone_len", on inside {[B*m-1:B*m+1]}, 1'b1)
    `CHK("tx_load", 1, ld)
    `CHK("tx_code", 4'h7, tone_ctl.code)
    if (cp)
    begin
      // Pin shows the filter output; ready must still be pending
      cp_tone = 1'b0;
      repeat (B - 4) @(negedge sys_clk);
      rd_stat(4'h8);
      `CHK("cp_pin", 1'b1, irq_oe)
      cp_tone = 1'b1;
      repeat (B) @(negedge sys_clk);
    end
    else
    begin
      for (off = 0; off < 200 && irq_oe !== 1'b1; off++) @(negedge sys_clk);
      guard(off);
      `CHK("pause", off inside {[B-1:B+1]}, 1'b1)
      `CHK("od_data", 1'b0, irq_out)
    end
    rd_stat(4'hb);
    rd_stat(4'h8);
  endtask : t_burst

  // Received code and ready together, serviced in one poll
  task automatic t_rx();
    logic [3:0] st, rx;
    logic       o;
    int         n;
    host_u.cfg(4'h5, 4'h0);
    host_u.acc(ACC_TX_WR, 4'h9, st, o);
    rx_valid = 1'b1;
    rx_code  = 4'h5;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    for (n = 0; n < 200 && irq_oe !== 1'b1; n++) @(negedge sys_clk);
    guard(n);
    `CHK("rx_irq", n < 4, 1'b1)
    repeat (2 * B + 4) @(negedge sys_clk);
    host_u.service(4'h3, st, rx);
    `CHK("svc_status", 4'hf, st)
    `CHK("rx_data", 4'h5, rx)
    rd_stat(4'h8);
  endtask : t_rx

  // Free-running tone, ready never raised
  task automatic t_free();
    logic [3:0] d;
    logic       o;
    host_u.cfg(4'h5, 4'h1);
    host_u.acc(ACC_STAT_RD, 4'h0, d, o);
    host_u.acc(ACC_TX_WR, 4'h2, d, o);
    `CHK("write_oe", 1'b0, o)
    repeat (3 * B) @(negedge sys_clk);
    `CHK("free_tone", 1'b1, tone_ctl.tone_on)
    rd_stat(4'h8);
  endtask : t_free

  // Test mode routes steering to the pin
  task automatic t_test();
    logic [3:0] d;
    logic       o;
    int         v;
    host_u.cfg(4'h0, 4'h2);
    repeat (4 * B) @(negedge sys_clk);
    host_u.acc(ACC_STAT_RD, 4'h0, d, o);
    for (v = 1; v >= 0; v--)
    begin
      steer_delayed = v[0];
      repeat (3) @(negedge sys_clk);
      `CHK("test_pin", v[0], irq_oe)
      rd_stat({~v[0], 3'h0});
    end
  endtask : t_test

  initial
  begin
    repeat (10) @(negedge sys_clk);
    `CHK("tone_rst", '0, tone_ctl)
    `CHK("pin_rst", 1'b0, irq_oe)
    rst_b = 1'b1;
    host_u.sw_reset();
    rd_stat(4'h8);
    t_sel();
    t_burst(1'b0);
    t_burst(1'b1);
    t_rx();
    t_free();
    t_test();
    end_of_test();
  end
endmodule : dtc_ctrl_status_test
